// ---- design/tfpa_frame_src.sv ----
// byte content of a transport frame at a given byte index
`timescale 1ns/100ps
`include "tfpa_cfg.svh"
module tfpa_frame_src (
  // position and frame layout
  input wire logic [15:0] idx,
  input wire logic odd,
  input wire logic [15:0] data_part_size,
  input wire logic [15:0] control_part_size,
  // payload source
  input wire logic [7:0] payload_byte,
  input wire logic payload_avail,
  // byte for the line, payload take and control-part flag
  output logic [7:0] byte_out,
  output logic take,
  output logic is_ctrl
);
  logic [7:0] hdr_byte;
  wire in_hdr = idx < `TFPA_HDR_BYTES;
  wire [15:0] pos = idx - `TFPA_HDR_BYTES;
  wire [16:0] dc_end = 17'(data_part_size) + 17'(control_part_size);
  wire in_data = !in_hdr && (pos < data_part_size);
  wire in_ctrl = !in_hdr && !in_data && (17'(pos) < dc_end);
  wire [23:0] sync = odd ? ~`TFPA_SYNC0 : `TFPA_SYNC0;

  always_comb begin
    case (idx[2:0])
      3'h0: hdr_byte = `TFPA_ERR_BYTE;
      3'h1: hdr_byte = sync[23:16];
      3'h2: hdr_byte = sync[15:8];
      3'h3: hdr_byte = sync[7:0];
      3'h4: hdr_byte = data_part_size[15:8];
      3'h5: hdr_byte = data_part_size[7:0];
      3'h6: hdr_byte = control_part_size[15:8];
      default: hdr_byte = control_part_size[7:0];
    endcase
  end

  // payload passes untouched, no coding added
  assign take = (in_data || in_ctrl) && payload_avail;
  // missing data part bytes and the frame tail become padding
  assign byte_out = in_hdr ? hdr_byte : (take ? payload_byte : `TFPA_PAD_BYTE);
  assign is_ctrl = in_ctrl;
endmodule

// ---- design/tfpa_top.sv ----
// transport frame physical adapter: framing, serial carriers and APB registers
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/100ps
`include "tfpa_cfg.svh"
// Overview of operation
// - clock-data mode frame length is N times 24
// - clock-data mode uses only clock and data; tx_en is still driven high while running
// - transmit clock echoes the receive clock
// - no protection coding; bytes pass unchanged
// - slot mode: one slot, 1152-byte frames
// - interface carries sixteen slots; one used here
// - byte 44 bit 0 starts the slot
// - audio mode: whole frame, 4608-byte frames
// - payload only in subframe slots 12-27
// - no audio-to-transport alignment; sync word aligns
// - validity bit always one
// - channel status bytes 0, 1, 2; byte 1 high nibble set from ctrl
// - G.704 link: 1920 user, 128 network
// - high-capacity variant: 5592/120/48 bytes
// - strong variant: 5376/336/48 bytes
// - G.704 needs timestamps and RS coding; neither is built here, so G.704 modes stay idle
// - sync word alternates with its complement
// - header sizes; 8 plus sizes within length
// - unused bytes padded with 0x55
module tfpa_top (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // line side
  input wire logic link_clk,
  input wire logic slot_sync_marker,
  input wire logic slot_active,
  output logic tx_clk,
  output logic tx_data,
  output logic tx_en,
  output logic subframe_start,
  // payload source
  input wire logic [7:0] payload_byte,
  input wire logic payload_avail,
  output logic payload_take,
  output logic payload_part
);
  logic rst_q1, rst_q2;
  wire rst_n = rst_q2;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end

  // pin inputs: three flops, a change counts once stages two and three agree
  wire [2:0] pin_in = {slot_active, slot_sync_marker, link_clk};
  logic [2:0] pin_s1, pin_s2, pin_s3, pin_f, pin_prev;
  wire [2:0] next_pin_f;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_flt
      assign next_pin_f[g] = (pin_s2[g] == pin_s3[g]) ? pin_s3[g] : pin_f[g];
    end
  endgenerate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      pin_s3 <= 3'h0;
      pin_f <= 3'h0;
      pin_prev <= 3'h0;
    end else begin
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f <= next_pin_f;
      pin_prev <= pin_f;
    end
  end
  // data changes on the falling line clock edge so the far end samples on the rising one
  wire clk_fall = pin_prev[0] && !pin_f[0];
  wire mark_rise = !pin_prev[1] && pin_f[1];
  wire slot_on = pin_f[2];

  // registers
  logic [15:0] ctrl;
  logic [31:0] sizes;
  wire [2:0] mode_bits = ctrl[`TFPA_CTRL_MODE_LSB +: 3];
  wire [7:0] n_mult = ctrl[`TFPA_CTRL_N_LSB +: 8];
  wire [3:0] cs1_hi = ctrl[`TFPA_CTRL_CS_LSB +: 4];
  tfpa_pkg::tfpa_mode_t mode_cfg;
  assign mode_cfg = tfpa_pkg::tfpa_mode_t'(mode_bits);

  logic [15:0] cfg_tfl;
  logic cfg_ok;
  always_comb begin
    cfg_ok = 1'b1;
    case (mode_cfg)
      tfpa_pkg::TFPA_V11: cfg_tfl = 16'(16'(n_mult) * `TFPA_V11_BYTES_PER_N);
      tfpa_pkg::TFPA_SLOT: cfg_tfl = `TFPA_TFL_SLOT;
      tfpa_pkg::TFPA_IEC: cfg_tfl = `TFPA_TFL_IEC;
      // no timestamp or RS coder here, so error-protected modes stay idle
      tfpa_pkg::TFPA_G704A: begin
        cfg_tfl = `TFPA_TFL_G704A;
        cfg_ok = 1'b0;
      end
      tfpa_pkg::TFPA_G704B: begin
        cfg_tfl = `TFPA_TFL_G704B;
        cfg_ok = 1'b0;
      end
      default: begin
        cfg_tfl = `TFPA_TFL_SLOT;
        cfg_ok = 1'b0;
      end
    endcase
  end
  wire [17:0] hdr_need = 18'(`TFPA_HDR_BYTES) + 18'(sizes[15:0]) + 18'(sizes[31:16]);
  wire hdr_bad = hdr_need > 18'(cfg_tfl);

  // frame state latched at each boundary
  tfpa_pkg::tfpa_mode_t mode_l;
  logic [15:0] tfl_l, dfs_l, cfs_l, frame_cnt, idx;
  logic [7:0] n_l, shift;
  logic [2:0] cnt;
  logic run_l, unsup_l, hdr_err, odd, fresh, mark_pend;

  // audio subframe counters, free of the transport frame
  logic [4:0] ts;
  logic sf, par;
  logic [7:0] frm;
  wire in_data_ts = (ts >= `TFPA_TS_DATA_LO) && (ts <= `TFPA_TS_DATA_HI);
  wire is_v11 = mode_l == tfpa_pkg::TFPA_V11;
  wire is_slot = mode_l == tfpa_pkg::TFPA_SLOT;
  wire is_iec = mode_l == tfpa_pkg::TFPA_IEC;
  wire iec_tick = run_l && clk_fall && is_iec;
  wire bit_tick = run_l && clk_fall && (is_v11 || (is_slot && slot_on) || (is_iec && in_data_ts));

  // only one slot is ours; slot_active marks it among the sixteen
  wire force_mark = is_slot && (mark_pend || mark_rise);
  wire load = bit_tick && ((cnt == 3'h0) || force_mark);
  wire wrap = fresh || (idx >= tfl_l - 16'h0001);
  wire [15:0] next_idx = wrap ? 16'h0000 : idx + 16'h0001;
  wire [15:0] load_idx = force_mark ? `TFPA_IDX_SLOT_FIRST : next_idx;
  wire boundary = load && (load_idx == 16'h0000);
  wire cfg_take = boundary || !run_l;

  logic [7:0] src_byte;
  logic src_take, src_ctrl;
  tfpa_frame_src u_src (
    .idx(load_idx),
    .odd(odd),
    .data_part_size(dfs_l),
    .control_part_size(cfs_l),
    .payload_byte(payload_byte),
    .payload_avail(payload_avail),
    .byte_out(src_byte),
    .take(src_take),
    .is_ctrl(src_ctrl)
  );

  // b0 is the most significant bit of each byte and goes out first
  wire out_bit = load ? src_byte[7] : shift[7];
  wire [7:0] cs_byte = (frm[7:3] == 5'h00) ? `TFPA_CS0 :
                       (frm[7:3] == 5'h01) ? {cs1_hi, `TFPA_CS1_LO} :
                       (frm[7:3] == 5'h02) ? `TFPA_CS2 : 8'h00;
  wire cs_bit = cs_byte[frm[2:0]];
  wire iec_bit = in_data_ts ? out_bit :
                 (ts == `TFPA_TS_V) ? 1'b1 :
                 (ts == `TFPA_TS_C) ? cs_bit :
                 (ts == `TFPA_TS_P) ? par : 1'b0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_l <= tfpa_pkg::TFPA_V11;
      tfl_l <= `TFPA_TFL_SLOT;
      dfs_l <= 16'h0000;
      cfs_l <= 16'h0000;
      n_l <= 8'h00;
      run_l <= 1'b0;
      unsup_l <= 1'b0;
      hdr_err <= 1'b0;
    end else if (cfg_take) begin
      mode_l <= mode_cfg;
      tfl_l <= cfg_tfl;
      n_l <= n_mult;
      // a bad header goes out with zero sizes and an all-padding frame body
      dfs_l <= hdr_bad ? 16'h0000 : sizes[15:0];
      cfs_l <= hdr_bad ? 16'h0000 : sizes[31:16];
      run_l <= ctrl[`TFPA_CTRL_EN] && cfg_ok;
      unsup_l <= !cfg_ok;
      hdr_err <= hdr_bad;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx <= 16'h0000;
      shift <= 8'h00;
      cnt <= 3'h0;
      fresh <= 1'b1;
      odd <= 1'b1;
      frame_cnt <= 16'h0000;
      mark_pend <= 1'b0;
    end else if (!run_l) begin
      cnt <= 3'h0;
      fresh <= 1'b1;
      mark_pend <= 1'b0;
    end else begin
      mark_pend <= is_slot && !load && (mark_pend || mark_rise);
      if (load) begin
        idx <= load_idx;
        shift <= {src_byte[6:0], 1'b0};
        cnt <= 3'h7;
        fresh <= 1'b0;
      end else if (bit_tick) begin
        shift <= {shift[6:0], 1'b0};
        cnt <= cnt - 3'h1;
      end
      if (boundary) begin
        odd <= !odd;
        frame_cnt <= frame_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ts <= 5'h00;
      sf <= 1'b0;
      frm <= 8'h00;
      par <= 1'b0;
    end else if (iec_tick) begin
      ts <= ts + 5'h01;
      par <= (ts == `TFPA_TS_P) ? 1'b0 : (par ^ iec_bit);
      if (ts == `TFPA_TS_P) begin
        sf <= !sf;
        if (sf) begin
          frm <= (frm == `TFPA_IEC_LAST_FRM) ? 8'h00 : frm + 8'h01;
        end
      end
    end
  end

  // line and payload outputs: clock and data, line enable, subframe start, payload take and part
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_clk <= 1'b0;
      tx_data <= 1'b0;
      tx_en <= 1'b0;
      subframe_start <= 1'b0;
      payload_take <= 1'b0;
      payload_part <= 1'b0;
    end else begin
      tx_clk <= pin_f[0];
      tx_en <= run_l && (!is_slot || slot_on);
      subframe_start <= iec_tick && (ts == 5'h00);
      payload_take <= load && src_take;
      if (load) begin
        payload_part <= src_ctrl;
      end
      if (iec_tick) begin
        tx_data <= iec_bit;
      end else if (bit_tick) begin
        tx_data <= out_bit;
      end
    end
  end

  // APB slave: one wait state, answer flopped
  wire acc = psel && penable;
  wire wr_en = acc && pwrite && pready;
  wire hit_ctrl = paddr == `TFPA_OFF_CTRL;
  wire hit_sizes = paddr == `TFPA_OFF_SIZES;
  wire hit_status = paddr == `TFPA_OFF_STATUS;
  wire hit_caps = paddr == `TFPA_OFF_CAPS;
  wire mapped = hit_ctrl || hit_sizes || hit_status || hit_caps;
  wire [31:0] status_word = {frame_cnt, 10'h000, mode_l, odd, unsup_l, hdr_err};
  // capacity split of the protected variants, for software sizing
  wire [31:0] caps_word = (mode_cfg == tfpa_pkg::TFPA_G704B) ?
                          {`TFPA_G704B_FEC, `TFPA_G704B_DATA} :
                          {`TFPA_G704A_FEC, `TFPA_G704A_DATA};
  wire [31:0] rd_mux = hit_ctrl ? {16'h0000, ctrl} : hit_sizes ? sizes :
                       hit_status ? status_word : hit_caps ? caps_word : 32'h0000_0000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      ctrl <= `TFPA_CTRL_RST;
      sizes <= `TFPA_SIZES_RST;
    end else begin
      pready <= acc && !pready;
      prdata <= (acc && !pready && !pwrite) ? rd_mux : 32'h0000_0000;
      pslverr <= acc && !pready && !mapped;
      if (wr_en && hit_ctrl) begin
        ctrl <= pwdata[15:0];
      end
      if (wr_en && hit_sizes) begin
        sizes <= pwdata;
      end
    end
  end

  // checks
  logic [7:0] sync_hist;
  logic sync_seen;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_hist <= 8'h00;
      sync_seen <= 1'b0;
    end else if (load && load_idx == 16'h0001) begin
      sync_hist <= src_byte;
      sync_seen <= 1'b1;
    end
  end
  wire [17:0] used_end = 18'(`TFPA_HDR_BYTES) + 18'(dfs_l) + 18'(cfs_l);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_sync_alt;
    load && load_idx == 16'h0001 && sync_seen |->
      src_byte == ~sync_hist && (src_byte == 8'h1F || src_byte == 8'hE0);
  endproperty
  a_sync_alt: assert property (p_sync_alt) else $error("sync word did not alternate");
  property p_pad;
    load && 18'(load_idx) >= used_end |-> src_byte == `TFPA_PAD_BYTE;
  endproperty
  a_pad: assert property (p_pad) else $error("tail byte is not padding");
  property p_hdr_fit;
    run_l |-> used_end <= 18'(tfl_l);
  endproperty
  a_hdr_fit: assert property (p_hdr_fit) else $error("header sizes exceed frame length");
  property p_tfl_v11;
    run_l && is_v11 |-> tfl_l == 16'(16'(n_l) * 16'h0018);
  endproperty
  a_tfl_v11: assert property (p_tfl_v11) else $error("clock-data frame length wrong");
  property p_tfl_fixed;
    run_l && (is_slot || is_iec) |-> tfl_l == (is_slot ? 16'h0480 : 16'h1200);
  endproperty
  a_tfl_fixed: assert property (p_tfl_fixed) else $error("fixed frame length wrong");
  property p_valid;
    iec_tick && ts == 5'h1C |=> tx_data;
  endproperty
  a_valid: assert property (p_valid) else $error("validity bit not one");
  property p_cs;
    iec_tick && ts == 5'h1E |=> tx_data == ((frm inside {8'h00, 8'h01, 8'h07, 8'h08, 8'h13}) ||
      (frm >= 8'h0C && frm <= 8'h0F && cs1_hi[frm[1:0]]));
  endproperty
  a_cs: assert property (p_cs) else $error("channel status bit wrong");
  property p_iec_slots;
    bit_tick && is_iec |-> ts >= 5'h0C && ts <= 5'h1B;
  endproperty
  a_iec_slots: assert property (p_iec_slots) else $error("payload outside data slots");
  property p_echo;
    $changed(pin_f[0]) |=> tx_clk == $past(pin_f[0]);
  endproperty
  a_echo: assert property (p_echo) else $error("transmit clock not echoed");
  property p_latch;
    !$past(cfg_take) |-> $stable(mode_l) && $stable(n_l);
  endproperty
  a_latch: assert property (p_latch) else $error("mode changed inside a frame");
  property p_pass;
    load && src_take |-> src_byte == payload_byte ##1 payload_take;
  endproperty
  a_pass: assert property (p_pass) else $error("payload byte altered");
  property p_marker;
    bit_tick && force_mark |=> idx == 16'h0034 && cnt == 3'h7;
  endproperty
  a_marker: assert property (p_marker) else $error("slot does not start at byte 44");
  property p_g704_split;
    `TFPA_G704A_DATA + `TFPA_G704A_FEC + `TFPA_G704_MGMT == `TFPA_G704_MF_BYTES &&
    `TFPA_G704B_DATA + `TFPA_G704B_FEC + `TFPA_G704_MGMT == `TFPA_G704_MF_BYTES &&
    `TFPA_G704_USER_KBPS + `TFPA_G704_NET_KBPS == `TFPA_G704_LINE_KBPS;
  endproperty
  a_g704_split: assert property (p_g704_split) else $error("capacity split wrong");

  c_frame_wrap: cover property (boundary && !fresh && is_v11);
  c_iec_block: cover property (iec_tick && ts == 5'h1F && sf && frm == 8'hBF);
  c_slot_mark: cover property (bit_tick && force_mark);
  c_bad_hdr: cover property (hdr_err && run_l);
endmodule

// ---- pkg/tfpa_cfg.svh ----
// constants of the transport frame physical adapter
`ifndef TFPA_CFG_SVH
`define TFPA_CFG_SVH
// transport frame layout
`define TFPA_FRAME_MS 24
`define TFPA_HDR_BYTES 16'h0008
`define TFPA_ERR_BYTE 8'h00
`define TFPA_SYNC0 24'h1F90CA
`define TFPA_PAD_BYTE 8'h55
`define TFPA_V11_BYTES_PER_N 16'h0018
`define TFPA_TFL_SLOT 16'h0480
`define TFPA_TFL_IEC 16'h1200
`define TFPA_TFL_G704A 16'h15DC
`define TFPA_TFL_G704B 16'h1504
// absolute index of frame byte 44 (header bytes come first)
`define TFPA_IDX_SLOT_FIRST 16'h0034
// G.704 capacity split per 24 ms multiframe
`define TFPA_G704_LINE_KBPS 16'h0800
`define TFPA_G704_USER_KBPS 16'h0780
`define TFPA_G704_NET_KBPS 16'h0080
`define TFPA_G704_MF_BYTES 16'h1680
`define TFPA_G704A_DATA 16'h15D8
`define TFPA_G704A_FEC 16'h0078
`define TFPA_G704B_DATA 16'h1500
`define TFPA_G704B_FEC 16'h0150
`define TFPA_G704_MGMT 16'h0030
// audio subframe time slots
`define TFPA_TS_DATA_LO 5'h0C
`define TFPA_TS_DATA_HI 5'h1B
`define TFPA_TS_V 5'h1C
`define TFPA_TS_C 5'h1E
`define TFPA_TS_P 5'h1F
`define TFPA_IEC_LAST_FRM 8'hBF
`define TFPA_CS0 8'h83
`define TFPA_CS1_LO 4'h1
`define TFPA_CS2 8'h08
// register map and fields
`define TFPA_OFF_CTRL 12'h000
`define TFPA_OFF_SIZES 12'h004
`define TFPA_OFF_STATUS 12'h008
`define TFPA_OFF_CAPS 12'h00C
`define TFPA_CTRL_RST 16'h0200
`define TFPA_SIZES_RST 32'h0000_0000
`define TFPA_CTRL_EN 0
`define TFPA_CTRL_MODE_LSB 1
`define TFPA_CTRL_N_LSB 4
`define TFPA_CTRL_CS_LSB 12
`endif

// ---- pkg/tfpa_pkg.sv ----
// types of the transport frame physical adapter
package tfpa_pkg;
  typedef enum logic [2:0] {TFPA_V11, TFPA_SLOT, TFPA_IEC, TFPA_G704A, TFPA_G704B} tfpa_mode_t;
endpackage

// ---- verification/tb_transport_frame_phys_adapter.sv ----
// self-checking bench of the transport frame physical adapter
`timescale 1ns/100ps
`include "tfpa_cfg.svh"
module tb_transport_frame_phys_adapter;
  logic clk, reset_n, psel, penable, pwrite, payload_avail, pay_step;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, link_clk, slot_sync_marker, slot_active;
  logic tx_clk, tx_data, tx_en, subframe_start, payload_take, payload_part;
  logic [7:0] payload_byte;
  int n_mismatch, n_checks;

  tfpa_top i_dut (.clk, .reset_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .link_clk, .slot_sync_marker, .slot_active, .tx_clk, .tx_data, .tx_en,
    .subframe_start, .payload_byte, .payload_avail, .payload_take, .payload_part);
  tfpa_far_end i_far (.clk, .tx_clk, .tx_data, .subframe_start, .link_clk, .slot_sync_marker,
    .slot_active);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  logic [5:0] part_log;
  int n_take;
  // first six taken bytes: which part each one came from
  always @(posedge clk) begin
    if (pay_step && payload_take === 1'b1) begin
      payload_byte <= payload_byte + 8'h01;
      if (n_take < 6) part_log[n_take] <= payload_part;
      n_take <= n_take + 1;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("apb answer", 32'h1, 32'(pready));
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so a following request never re-drives psel in the same step
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    i_far.bits.delete();
    i_far.sf.delete();
  endtask

  task automatic wait_len(input int nbits, input int nsf);
    int k;
    for (k = 0; k < 20000 && (i_far.bits.size() < nbits || i_far.sf.size() < nsf); k++)
      @(posedge clk);
    chk("line progress", 32'h1, 32'(k < 20000));
  endtask

  function automatic logic [31:0] pick(ref logic q[$], input int at, input int n);
    logic [31:0] v;
    v = 32'h0;
    for (int i = 0; i < n; i++) v = {v[30:0], q[at + i]};
    return v;
  endfunction

  function automatic int find(ref logic q[$], input logic [31:0] pat);
    for (int i = 0; i + 32 <= q.size(); i++) if (pick(q, i, 32) === pat) return i;
    return -1;
  endfunction

  task automatic t_regs;
    logic [31:0] r;
    logic e;
    do_reset;
    apb(1'b0, `TFPA_OFF_CTRL, 32'h0, r, e);
    chk("ctrl reset", 32'h0000_0200, r);
    apb(1'b0, `TFPA_OFF_SIZES, 32'h0, r, e);
    chk("sizes reset", 32'h0, r);
    wr(`TFPA_OFF_CTRL, 32'h0000_0008);
    apb(1'b0, `TFPA_OFF_CAPS, 32'h0, r, e);
    chk("caps strong variant", 32'h0150_1500, r);
    wr(`TFPA_OFF_CAPS, 32'hFFFF_FFFF);
    wr(`TFPA_OFF_CTRL, 32'h0000_0007);
    apb(1'b0, `TFPA_OFF_CAPS, 32'h0, r, e);
    chk("caps high capacity", 32'h0078_15D8, r);
    apb(1'b0, 12'h010, 32'h0, r, e);
    chk("unmapped error", 32'h1, 32'(e));
    apb(1'b0, `TFPA_OFF_STATUS, 32'h0, r, e);
    chk("unsupported mode", 32'h1, 32'(r[1]));
    chk("no line output", 32'h0, 32'(tx_en));
    chk("latched mode", 32'h3, 32'(r[5:3]));
    wr(`TFPA_OFF_CTRL, 32'h0000_000F);
    apb(1'b0, `TFPA_OFF_STATUS, 32'h0, r, e);
    chk("invalid mode code", 32'h1, 32'(r[1]));
    chk("no line on invalid code", 32'h0, 32'(tx_en));
  endtask

  task automatic t_clock_data;
    logic [7:0] exp[$];
    int at;
    do_reset;
    payload_byte <= 8'hA0;
    n_take <= 0;
    pay_step <= 1'b1;
    wr(`TFPA_OFF_SIZES, 32'h0001_0002);
    wr(`TFPA_OFF_CTRL, 32'h0000_0011);
    wait_len(600, 0);
    chk("line enabled", 32'h1, 32'(tx_en));
    for (int f = 0; f < 2; f++) begin
      exp = {exp, 8'h00, f ? 8'hE0 : 8'h1F, f ? 8'h6F : 8'h90, f ? 8'h35 : 8'hCA};
      exp = {exp, 8'h00, 8'h02, 8'h00, 8'h01};
      for (int k = 0; k < 3; k++) exp.push_back(8'hA0 + 8'(3 * f + k));
      for (int k = 11; k < 24; k++) exp.push_back(8'h55);
    end
    at = find(i_far.bits, 32'h001F_90CA);
    chk("sync found", 32'h1, 32'(at >= 0));
    for (int k = 0; k < 48; k++)
      chk("frame byte", 32'(exp[k]), pick(i_far.bits, at + 8 * k, 8));
    // two frames of two data bytes then one control byte
    chk("payload part", 32'h0000_0024, 32'(part_log));
    pay_step <= 1'b0;
  endtask

  task automatic t_slot;
    do_reset;
    // source side: stream count stays at eight, the adapter copies content blind
    payload_byte <= 8'hA5;
    wr(`TFPA_OFF_SIZES, 32'h0000_002D);
    wr(`TFPA_OFF_CTRL, 32'h0000_0013);
    chk("idle outside slot", 32'h0, 32'(tx_en));
    i_far.slot_burst(16);
    wait_len(16, 0);
    chk("first slot byte", 32'h0000_00A5, pick(i_far.bits, 0, 8));
    chk("second slot byte", 32'h0000_0055, pick(i_far.bits, 8, 8));
    repeat (8) @(posedge clk);
    chk("idle after slot", 32'h0, 32'(tx_en));
  endtask

  task automatic t_audio;
    logic p[$];
    logic [23:0] cs;
    int at;
    do_reset;
    wr(`TFPA_OFF_SIZES, 32'h0);
    wr(`TFPA_OFF_CTRL, 32'h0000_9005);
    wait_len(0, 50);
    // the subframe before the first marker may already hold the frame start
    for (int s = -1; s < 48; s++) begin
      at = (s < 0) ? i_far.sf[0] - 32 : i_far.sf[s];
      for (int j = 12; j < 28; j++) if (at + j >= 0) p.push_back(i_far.bits[at + j]);
      if (s >= 0) begin
        chk("aux slots", 32'h0, pick(i_far.bits, at, 12));
        chk("validity", 32'h1, pick(i_far.bits, at + 28, 1));
        chk("parity", 32'h0, 32'(^pick(i_far.bits, at + 4, 28)));
        if (s[0] == 1'b0) cs = {cs[22:0], i_far.bits[at + 30]};
      end
    end
    chk("channel status", 32'h00C1_8910, 32'(cs));
    chk("transport mode flag", 32'h8, 32'(cs[15:12]));
    at = find(p, 32'h001F_90CA);
    chk("sizes in payload", 32'h0, pick(p, at + 32, 32));
    chk("padding", 32'h55, pick(p, at + 64, 8));
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    payload_byte = 8'h00;
    payload_avail = 1'b1;
    pay_step = 1'b0;
    n_take = 0;
    n_mismatch = 0;
    n_checks = 0;
    @(posedge clk);
    t_regs;
    t_clock_data;
    t_slot;
    t_audio;
    print_verdict;
  end

  initial begin
    #4000000;
    n_mismatch++;
    $display("watchdog expired");
    print_verdict;
  end
endmodule

// ---- verification/tfpa_far_end.sv ----
// far-end line model: receive clock source, slot timing and bit capture
`timescale 1ns/100ps
module tfpa_far_end (
  // clocks
  input wire logic clk,
  input wire logic tx_clk,
  // line from the adapter
  input wire logic tx_data,
  input wire logic subframe_start,
  // line to the adapter
  output logic link_clk,
  output logic slot_sync_marker,
  output logic slot_active
);
  logic bits[$];
  int sf[$];
  initial begin
    link_clk = 1'b0;
    slot_sync_marker = 1'b0;
    slot_active = 1'b0;
    forever #400 link_clk = ~link_clk;
  end
  // sampled mid-bit on the echoed clock, so a wrong echo shows up as wrong bits
  always @(posedge tx_clk) bits.push_back(tx_data);
  always @(posedge clk) if (subframe_start === 1'b1) sf.push_back(bits.size());
  // one slot of nbits; capture restarts after the stale echo edge has passed
  task automatic slot_burst(input int nbits);
    @(posedge link_clk);
    slot_sync_marker = 1'b1;
    slot_active = 1'b1;
    #600 bits.delete();
    @(posedge link_clk);
    slot_sync_marker = 1'b0;
    repeat (nbits - 1) @(posedge link_clk);
    slot_active = 1'b0;
  endtask
endmodule
